// [design/cmsg_top.sv]
// Our own choice: the plain strobed port.
`timescale 1ns/10ps
`include "cmsg_map.svh"
module cmsg_top
   import cmsg_pkg::*;
#(
   parameter logic [3:0] SILICON_REVISION = 4'h9 // Arbitrary value
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [7:0] rd_data,
   output logic irq,
   input wire logic pix_clk_in,
   input wire logic two_lane_active,
   input wire logic lane0_lock,
   input wire logic lane1_lock,
   input wire logic audio_pll_lock,
   input wire logic pin0_func_value,
   input wire logic pin0_far_value,
   input wire logic pin0_in,
   output logic pin0_out,
   output logic pin0_oe,
   input wire logic second_port_pin0_func_value,
   input wire logic second_port_pin0_far_value,
   input wire logic second_port_pin0_in,
   output logic second_port_pin0_out,
   output logic second_port_pin0_oe
);
   localparam logic [1:0] OSC_LAST = 2'(`CMSG_OSC_DIV_CYCLES - 1);

   // Returns {oe, out} for one pin from its four config bits
   function automatic logic [1:0] pin_drive(input logic [3:0] cfg, input logic func_v, input logic far_v);
      cmsg_pin_mode_t mode;
      mode = cmsg_pin_mode_t'({cfg[`CMSG_PIN_DIR], cfg[`CMSG_PIN_FSEL]});
      if (cfg[`CMSG_PIN_FAR]) begin
         pin_drive = {1'b1, far_v};
      end else begin
         unique case (mode)
            CMSG_FUNC_OUT: pin_drive = {1'b1, func_v};
            CMSG_GPIO_OUT: pin_drive = {1'b1, cfg[`CMSG_PIN_DRV]};
            CMSG_TRISTATE: pin_drive = 2'b00;
            CMSG_GPIO_IN: pin_drive = 2'b00;
         endcase
      end
   endfunction

   cmsg_meter_state_t meter_state_r;
   logic [7:0] count_r;
   logic [7:0] window_r;
   logic [1:0] osc_div_r;
   logic pix_prev_r;
   logic meter_done;
   logic osc_tick;
   logic pix_edge;

   logic [3:0] pin0_cfg_r;
   logic [3:0] port1_cfg_r;
   logic second_port_select_r;
   logic [3:0] irq_stat_r;
   logic [3:0] irq_mask_r;
   logic [3:0] irq_event;
   logic lock_prev_r;
   logic audio_prev_r;
   logic lane_prev_r;

   logic lock_now;
   logic [7:0] status_byte;
   logic [7:0] pin_byte;
   logic [7:0] rd_nxt;
   logic [1:0] drv0;
   logic [1:0] drv1;

   logic wr_meter;
   logic wr_pin;
   logic rd_irq;
   assign wr_meter = wr_en && (addr == `CMSG_ADDR_METER);
   assign wr_pin = wr_en && (addr == `CMSG_ADDR_PIN0);
   assign rd_irq = rd_en && (addr == `CMSG_ADDR_IRQ_STAT);

   // Pixel clock is sampled, so only rates below half of clk are counted faithfully
   assign pix_edge = pix_clk_in && !pix_prev_r;
   assign osc_tick = (osc_div_r == OSC_LAST);
   assign meter_done = (meter_state_r == CMSG_MEAS) && osc_tick && (window_r == 8'h01);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pix_prev_r <= 1'b0;
      end else begin
         pix_prev_r <= pix_clk_in;
      end
   end

   // Divider restarts on each meter write so the window is exactly value times the period
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         osc_div_r <= 2'h0;
      end else if (wr_meter || osc_tick) begin
         osc_div_r <= 2'h0;
      end else begin
         osc_div_r <= osc_div_r + 2'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meter_state_r <= CMSG_IDLE;
         window_r <= `CMSG_RST_BYTE;
      end else if (wr_meter) begin
         // A zero window ends at once with a zero count
         meter_state_r <= (wr_data == 8'h00) ? CMSG_IDLE : CMSG_MEAS;
         window_r <= wr_data;
      end else begin
         unique case (meter_state_r)
            CMSG_IDLE: meter_state_r <= CMSG_IDLE;
            CMSG_MEAS: begin
               if (osc_tick) begin
                  window_r <= window_r - 8'h01;
                  if (window_r == 8'h01) begin
                     meter_state_r <= CMSG_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         count_r <= `CMSG_RST_BYTE;
      end else if (wr_meter) begin
         count_r <= `CMSG_RST_BYTE;
      end else if (meter_state_r == CMSG_MEAS && pix_edge && count_r != `CMSG_COUNT_MAX) begin
         count_r <= count_r + 8'h01;
      end
   end

   assign lock_now = two_lane_active ? (lane0_lock && lane1_lock) : lane0_lock;

   always_comb begin
      status_byte = 8'h00;
      status_byte[`CMSG_ST_RSVD5] = 1'b1;
      status_byte[`CMSG_ST_TWO_LANE] = two_lane_active;
      status_byte[`CMSG_ST_AUDIO] = audio_pll_lock;
      status_byte[`CMSG_ST_LOCK] = lock_now;
   end

   // One stored config per port; the select steers access
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin0_cfg_r <= `CMSG_RST_NIB;
         port1_cfg_r <= `CMSG_RST_NIB;
      end else if (wr_pin) begin
         if (second_port_select_r) begin
            port1_cfg_r <= wr_data[3:0];
         end else begin
            pin0_cfg_r <= wr_data[3:0];
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         second_port_select_r <= 1'b0;
      end else if (wr_en && addr == `CMSG_ADDR_PORT_SEL) begin
         second_port_select_r <= wr_data[0];
      end
   end

   assign pin_byte = {SILICON_REVISION, second_port_select_r ? port1_cfg_r : pin0_cfg_r};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lock_prev_r <= 1'b0;
         audio_prev_r <= 1'b0;
         lane_prev_r <= 1'b0;
      end else begin
         lock_prev_r <= lock_now;
         audio_prev_r <= audio_pll_lock;
         lane_prev_r <= two_lane_active;
      end
   end

   always_comb begin
      irq_event = 4'h0;
      irq_event[`CMSG_IRQ_METER_DONE] = meter_done;
      irq_event[`CMSG_IRQ_LOCK_CHG] = lock_now != lock_prev_r;
      irq_event[`CMSG_IRQ_AUDIO_CHG] = audio_pll_lock != audio_prev_r;
      irq_event[`CMSG_IRQ_LANE_CHG] = two_lane_active != lane_prev_r;
   end

   // A read clears, but an event in the same cycle still lands
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_stat_r <= `CMSG_RST_NIB;
      end else if (rd_irq) begin
         irq_stat_r <= irq_event;
      end else begin
         irq_stat_r <= irq_stat_r | irq_event;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq_mask_r <= `CMSG_RST_NIB;
      end else if (wr_en && addr == `CMSG_ADDR_IRQ_MASK) begin
         irq_mask_r <= wr_data[3:0];
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_r & irq_mask_r);
      end
   end

   always_comb begin
      rd_nxt = 8'h00;
      unique case (addr)
         `CMSG_ADDR_METER: rd_nxt = count_r;
         `CMSG_ADDR_STATUS: rd_nxt = status_byte;
         `CMSG_ADDR_PIN0: rd_nxt = pin_byte;
         `CMSG_ADDR_IRQ_STAT: rd_nxt = {4'h0, irq_stat_r};
         `CMSG_ADDR_IRQ_MASK: rd_nxt = {4'h0, irq_mask_r};
         `CMSG_ADDR_PORT_SEL: rd_nxt = {7'h00, second_port_select_r};
         default: rd_nxt = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= rd_nxt;
      end else begin
         rd_data <= 8'h00;
      end
   end

   assign drv0 = pin_drive(pin0_cfg_r, pin0_func_value, pin0_far_value);
   assign drv1 = pin_drive(port1_cfg_r, second_port_pin0_func_value, second_port_pin0_far_value);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pin0_oe <= 1'b1;
         pin0_out <= 1'b0;
         second_port_pin0_oe <= 1'b1;
         second_port_pin0_out <= 1'b0;
      end else begin
         pin0_oe <= drv0[1];
         pin0_out <= drv0[1] & drv0[0];
         second_port_pin0_oe <= drv1[1];
         second_port_pin0_out <= drv1[1] & drv1[0];
      end
   end

   // Pin inputs are not read back here; the pad level is visible elsewhere
   logic unused_ok;
   assign unused_ok = pin0_in ^ second_port_pin0_in;
endmodule

// [design/cmsg_map.svh]
`ifndef CMSG_MAP_SVH
`define CMSG_MAP_SVH
// How it works
// - Any write to the rate meter register clears the edge count; a nonzero byte also starts a new timed measurement window.
// - The window lasts the written byte value times the 40 ns oscillator period, built from a clock divider.
// - A read of the rate meter register returns the pixel clock edges counted in the latest window.
// - The edge count stops at 8'hff and holds there instead of wrapping.
// - Status bit 4 reads 1 in two-lane operation and 0 in single-lane operation.
// - Status bit 3 reads 1 while the audio PLL is locked to the incoming audio serial clock.
// - Status bit 0 reads 1 while receiver clock recovery is locked to the recovered clock.
// - In two-lane operation status bit 0 reads 1 only when both receive channels are locked.
// - With the second port select set, the pin 0 register reaches the second port pin instead of the primary one.
// - The drive value bit reaches the pin only in general-purpose output mode with remote control off.
// - With the far control bit set the pin is forced to an output carrying the value from the remote end.
// - The two-bit setting decodes 00 functional output, 10 tri-state, 01 general-purpose output, 11 input.

`define CMSG_ADDR_METER 8'h1B
`define CMSG_ADDR_STATUS 8'h1C
`define CMSG_ADDR_PIN0 8'h1D
`define CMSG_ADDR_IRQ_STAT 8'h30
`define CMSG_ADDR_IRQ_MASK 8'h31
`define CMSG_ADDR_PORT_SEL 8'h32

`define CMSG_ST_LOCK 0
`define CMSG_ST_RSVD1 1
`define CMSG_ST_AUDIO 3
`define CMSG_ST_TWO_LANE 4
`define CMSG_ST_RSVD5 5

`define CMSG_PIN_FSEL 0
`define CMSG_PIN_DIR 1
`define CMSG_PIN_FAR 2
`define CMSG_PIN_DRV 3

`define CMSG_IRQ_METER_DONE 0
`define CMSG_IRQ_LOCK_CHG 1
`define CMSG_IRQ_AUDIO_CHG 2
`define CMSG_IRQ_LANE_CHG 3

`define CMSG_RST_BYTE 8'h00
`define CMSG_RST_NIB 4'h0
`define CMSG_COUNT_MAX 8'hFF
`define CMSG_CLK_PERIOD_NS 20
`define CMSG_OSC_PERIOD_NS 40
`define CMSG_OSC_DIV_CYCLES ((`CMSG_OSC_PERIOD_NS + `CMSG_CLK_PERIOD_NS - 1) / `CMSG_CLK_PERIOD_NS)
`endif

// [design/cmsg_pkg.sv]
package cmsg_pkg;
   typedef enum logic [0:0] {
      CMSG_IDLE = 1'b0,
      CMSG_MEAS = 1'b1
   } cmsg_meter_state_t;
   typedef enum logic [1:0] {
      CMSG_FUNC_OUT = 2'b00,
      CMSG_GPIO_OUT = 2'b01,
      CMSG_TRISTATE = 2'b10,
      CMSG_GPIO_IN = 2'b11
   } cmsg_pin_mode_t;
endpackage

// [test/cmsg_chk.sv]
`timescale 1ns/10ps
module cmsg_chk #(
   parameter logic [3:0] SILICON_REVISION = 4'h9 // Arbitrary value
)(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] addr,
   input wire logic rd_en,
   input wire logic [7:0] rd_data,
   input wire logic two_lane_active,
   input wire logic lane0_lock,
   input wire logic lane1_lock,
   input wire logic audio_pll_lock,
   input wire logic pin0_out,
   input wire logic pin0_oe,
   input wire logic second_port_pin0_out,
   input wire logic second_port_pin0_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic st;
   assign st = rd_en && addr == 8'h1C;
   property p_idle; !rd_en |=> rd_data == 8'h00; endproperty
   a_idle: assert property (p_idle) else $error("read data not idle");
   property p_lane; st |=> rd_data[4] == $past(two_lane_active); endproperty
   a_lane: assert property (p_lane) else $error("lane bit wrong");
   property p_audio; st |=> rd_data[3] == $past(audio_pll_lock); endproperty
   a_audio: assert property (p_audio) else $error("audio bit wrong");
   property p_one; st && !two_lane_active |=> rd_data[0] == $past(lane0_lock); endproperty
   a_one: assert property (p_one) else $error("lock bit wrong");
   property p_two; st && two_lane_active |=> rd_data[0] == $past(lane0_lock && lane1_lock); endproperty
   a_two: assert property (p_two) else $error("dual lock bit wrong");
   property p_rev; rd_en && addr == 8'h1D |=> rd_data[7:4] == SILICON_REVISION; endproperty
   a_rev: assert property (p_rev) else $error("revision wrong");
   property p_oe0; !pin0_oe |-> !pin0_out; endproperty
   a_oe0: assert property (p_oe0) else $error("pin0 idle drive");
   property p_oe1; !second_port_pin0_oe |-> !second_port_pin0_out; endproperty
   a_oe1: assert property (p_oe1) else $error("second pin idle drive");
endmodule
bind cmsg_top cmsg_chk #(.SILICON_REVISION(SILICON_REVISION)) chk_u (
   .clk(clk),
   .rst(rst),
   .addr(addr),
   .rd_en(rd_en),
   .rd_data(rd_data),
   .two_lane_active(two_lane_active),
   .lane0_lock(lane0_lock),
   .lane1_lock(lane1_lock),
   .audio_pll_lock(audio_pll_lock),
   .pin0_out(pin0_out),
   .pin0_oe(pin0_oe),
   .second_port_pin0_out(second_port_pin0_out),
   .second_port_pin0_oe(second_port_pin0_oe)
);

// [test/cmsg_far_model.sv]
`timescale 1ns/10ps
module cmsg_far_model (
   input wire logic clk,
   input wire logic go,
   input wire logic [7:0] n_edges,
   input wire logic [1:0] far_in,
   output logic pix_clk_in,
   output logic [1:0] far_out
);
   int left = 0;
   int ph = 0;
   initial pix_clk_in = 1'b0;
   // Pixel clock stands low between bursts
   always @(posedge clk) begin
      far_out <= far_in;
      if (go) begin
         left = n_edges;
         ph = 0;
      end else if (left > 0) begin
         ph = ph + 1;
         if (ph == 2) pix_clk_in <= 1'b1;
         if (ph == 4) begin
            pix_clk_in <= 1'b0;
            ph = 0;
            left = left - 1;
         end
      end
   end
endmodule

// [test/cmsg_tb_top.sv]
`timescale 1ns/10ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("unexpected at %0t: %s", $time, m); end end
module cmsg_tb_top;
   localparam logic [3:0] REV = 4'h5; // Arbitrary value
   logic clk = 0, rst = 1, wr_en = 0, rd_en = 0, go = 0, irq, pix, tl = 0, l0 = 0, l1 = 0, au = 0;
   logic [7:0] addr = 0, wr_data = 0, rd_data, k = 0, d;
   logic [1:0] fv = 0, far_in = 0, far, po, poe;
   int n_fail = 0, checks_done = 0, cfg [2] = '{0, 0}, e;
   always #10 clk = ~clk;
   cmsg_far_model far_u (.clk(clk), .go(go), .n_edges(k), .far_in(far_in), .pix_clk_in(pix), .far_out(far));
   cmsg_top #(.SILICON_REVISION(REV)) dut_u (.clk(clk), .rst(rst), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .irq(irq), .pix_clk_in(pix), .two_lane_active(tl),
      .lane0_lock(l0), .lane1_lock(l1), .audio_pll_lock(au), .pin0_func_value(fv[0]), .pin0_far_value(far[0]),
      .pin0_in(1'b0), .pin0_out(po[0]), .pin0_oe(poe[0]), .second_port_pin0_func_value(fv[1]),
      .second_port_pin0_far_value(far[1]), .second_port_pin0_in(1'b0), .second_port_pin0_out(po[1]),
      .second_port_pin0_oe(poe[1]));
   task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic g);
      @(posedge clk);
      addr <= a;
      wr_data <= v;
      wr_en <= 1'b1;
      go <= g;
      @(posedge clk);
      wr_en <= 1'b0;
      go <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      @(negedge clk);
      v = rd_data;
   endtask
   task automatic meas(input int n);
      e = (n > 8) ? (n - 4) / 2 : 0;
      k <= 8'(e);
      wr(8'h1B, 8'(n), 1'b1);
      repeat (2 * n + 6) @(posedge clk);
      k <= 8'd5;
      // Late edges fall after the window
      wr(8'h00, 8'h5A, 1'b1);
      repeat (30) @(posedge clk);
      rd(8'h1B, d);
      `CHK(d, 8'((e > 255) ? 255 : e), "edge count")
   endtask
   function automatic logic [1:0] pin_exp(input int c, input logic f, input logic r);
      if (c[2]) return {1'b1, r};
      case (c[1:0])
         2'b00: return {1'b1, f};
         2'b01: return {1'b1, c[3]};
         default: return 2'b00;
      endcase
   endfunction
   task print_verdict;
      if (n_fail == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #400000;
      n_fail++;
      print_verdict();
   end
   initial begin
      e = $urandom(50237);
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      foreach (cfg[i]) begin
         rd(8'h30 + 8'(i), d);
         `CHK(d, 8'h00, "reset value")
      end
      rd(8'h00, d);
      `CHK(d, 8'h00, "unmapped read")
      repeat (8) begin
         @(posedge clk);
         {tl, l0, l1, au} <= 4'($urandom);
         repeat (2) @(posedge clk);
         rd(8'h1C, d);
         `CHK(d, {3'b001, tl, au, 2'b00, l0 & (l1 | ~tl)}, "status")
      end
      rd(8'h30, d);
      for (int m = 1; m >= 0; m--) begin
         wr(8'h31, 8'(m), 1'b0);
         meas(20);
         `CHK(irq, 1'(m), "irq level")
         rd(8'h30, d);
         `CHK(d, 8'h01, "irq status")
         repeat (3) @(negedge clk);
         `CHK(irq, 1'b0, "irq clear")
      end
      meas(0);
      repeat (4) meas(9 + $urandom % 247);
      meas(255);
      for (int p = 0; p < 2; p++) begin
         wr(8'h32, 8'(p), 1'b0);
         for (int c = 0; c < 16; c++) begin
            @(posedge clk);
            fv <= 2'($urandom);
            far_in <= 2'($urandom);
            wr(8'h1D, {4'($urandom), 4'(c)}, 1'b0);
            cfg[p] = c;
            repeat (3) @(posedge clk);
            rd(8'h1D, d);
            `CHK(d, {REV, 4'(c)}, "pin config readback")
            `CHK({poe[0], po[0]}, pin_exp(cfg[0], fv[0], far[0]), "pin0")
            `CHK({poe[1], po[1]}, pin_exp(cfg[1], fv[1], far[1]), "second pin0")
         end
      end
      print_verdict();
   end
endmodule
